// ### design/cms_core_machine_state_regs.v
// core machine state, condition flags and exception cause registers with off-core move decode
`timescale 1ns/100ps
`include "cms_core_machine_state_regs.vh"

module cms_core_machine_state_regs (
	// clock and reset
	input  wire        ref_clk,
	input  wire        nrst,
	// special register move request
	input  wire        sprReq,
	input  wire        sprWrite,
	input  wire [4:0]  sprLo,
	input  wire [4:0]  sprHi,
	input  wire [0:31] sprWdata,
	output wire        sprBusy,
	output reg         sprAck,
	output reg  [0:31] sprRdata,
	output reg         emulIrq,
	// internal chip bus toward off-core registers
	output reg         busReq,
	output reg         busWrite,
	output reg  [0:31] busAddr,
	output reg  [0:31] busWdata,
	output reg  [2:0]  busTarget,
	input  wire        busAck,
	input  wire        busErr,
	input  wire [0:31] busRdata,
	// machine_state updates
	input  wire        msrWrEn,
	input  wire [0:31] msrWdata,
	input  wire        irqTake,
	input  wire        rfiTake,
	input  wire [0:2]  rfiBits,
	output reg  [0:2]  savedBits,
	output wire [0:31] machineState,
	// condition_flags updates
	input  wire        crMoveEn,
	input  wire [0:7]  crMoveMask,
	input  wire [0:31] crMoveData,
	input  wire        crLogicEn,
	input  wire [4:0]  crLogicBit,
	input  wire        crLogicVal,
	input  wire        cmpEn,
	input  wire [2:0]  cmpField,
	input  wire [0:3]  cmpResult,
	input  wire        intResultEn,
	input  wire [0:3]  integerResultField,
	input  wire        fpResultEn,
	input  wire [0:3]  floatResultField,
	input  wire        xerCopyEn,
	input  wire [2:0]  xerCopyField,
	output wire [0:31] conditionFlags,
	// fixed_exception_cause updates
	input  wire        wrapUpdEn,
	input  wire        wrapVal,
	input  wire        spillUpdEn,
	input  wire        spillVal,
	output wire [0:31] fixedExceptionCause,
	// instruction and interrupt qualification
	input  wire        extIrqReq,
	input  wire        decIrqReq,
	input  wire        mcheckReq,
	input  wire        privInstr,
	input  wire        fpInstr,
	output wire        extIrqAccept,
	output wire        decIrqAccept,
	output wire        mcheckAccept,
	output wire        privFault,
	output wire        fpFault,
	// decoded machine state controls
	output wire        lowPowerMode,
	output wire [1:0]  floatExcMode,
	output wire        stepTraceEn,
	output wire        branchTraceEn,
	output wire [11:0] vectorPrefix,
	output wire        fetchTranslate,
	output wire        dataTranslate,
	output wire        irqRecoverable,
	output wire        littleEndian
);

	// ------------------------------------------------------------------
	// states and decode
	// ------------------------------------------------------------------
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_BUS  = 2'h1;

	// masks follow the encoding table, high number bits first
	function [2:0] decodeTarget;
		input [4:0] hi;
		input [4:0] lo;
		begin
			if ((hi & 5'h10) == 5'h00)
				decodeTarget = `CMS_TGT_TIMER;
			else if (hi == 5'h13 && (lo & 5'h08) == 5'h00)
				decodeTarget = `CMS_TGT_SIU;
			else if ((hi & 5'h1E) == 5'h18 && (lo & 5'h08) == 5'h00)
				decodeTarget = `CMS_TGT_IMMU;
			else if ((hi & 5'h1E) == 5'h18)
				decodeTarget = `CMS_TGT_DMMU;
			else if (hi == 5'h11 && (lo & 5'h0C) == 5'h00)
				decodeTarget = `CMS_TGT_ICACHE;
			else if (hi == 5'h11 && (lo & 5'h0C) == 5'h08)
				decodeTarget = `CMS_TGT_DCACHE;
			else if ((hi & 5'h1C) == 5'h10 || (hi & 5'h1C) == 5'h18)
				decodeTarget = `CMS_TGT_CORE_EXT;
			else
				decodeTarget = `CMS_TGT_NONE;
		end
	endfunction

	// exact special register number match, shared by the local registers
	function sprMatch;
		input [4:0] hi;
		input [4:0] lo;
		input [4:0] wantHi;
		input [4:0] wantLo;
		begin
			sprMatch = (hi == wantHi) && (lo == wantLo);
		end
	endfunction

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	reg  [0:31] msr_q;
	reg  [0:31] msr_d;
	reg  [0:31] cr_q;
	reg  [0:31] cr_d;
	reg  [0:31] xer_q;
	reg  [0:31] xer_d;
	reg  [1:0]  state_q;

	wire [2:0]  reqTarget;
	wire        isXer;
	wire        isDebugInstr;
	wire        xerMove;
	wire        localReq;

	assign reqTarget    = decodeTarget(sprHi, sprLo);
	assign isXer        = sprMatch(sprHi, sprLo, `CMS_SPR_XER_HI, `CMS_SPR_XER_LO);
	assign isDebugInstr = sprMatch(sprHi, sprLo, `CMS_SPR_DPI_HI, `CMS_SPR_DPI_LO);
	assign localReq     = isXer || isDebugInstr;
	assign xerMove      = sprReq && (state_q == ST_IDLE) && isXer && sprWrite;
	assign sprBusy      = (state_q != ST_IDLE);

	// ------------------------------------------------------------------
	// special register move sequencer
	// ------------------------------------------------------------------
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_q   <= ST_IDLE;
			sprAck    <= 1'b0;
			sprRdata  <= 32'h0000_0000;
			emulIrq   <= 1'b0;
			busReq    <= 1'b0;
			busWrite  <= 1'b0;
			busAddr   <= 32'h0000_0000;
			busWdata  <= 32'h0000_0000;
			busTarget <= `CMS_TGT_NONE;
		end else begin
			sprAck  <= 1'b0;
			emulIrq <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (sprReq && localReq) begin
						sprAck <= 1'b1;
						// undefined read value is driven as zero
						if (isDebugInstr)
							sprRdata <= 32'h0000_0000;
						else
							sprRdata <= xer_q;
					end else if (sprReq && reqTarget == `CMS_TGT_NONE) begin
						sprAck  <= 1'b1;
						emulIrq <= 1'b1;
					end else if (sprReq) begin
						state_q   <= ST_BUS;
						busReq    <= 1'b1;
						busWrite  <= sprWrite;
						busAddr   <= {18'h0_0000, sprLo, sprHi, 4'h0};
						busWdata  <= sprWdata;
						busTarget <= reqTarget;
					end
				end
				ST_BUS: begin
					if (busErr) begin
						state_q <= ST_IDLE;
						busReq  <= 1'b0;
						sprAck  <= 1'b1;
						emulIrq <= 1'b1;
					end else if (busAck) begin
						state_q  <= ST_IDLE;
						busReq   <= 1'b0;
						sprAck   <= 1'b1;
						sprRdata <= busWrite ? sprRdata : busRdata;
					end
				end
				default: begin
					state_q <= ST_IDLE;
					busReq  <= 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// machine state
	// ------------------------------------------------------------------
	// a whole-word write keeps reserved bits as written
	always @* begin
		msr_d = msr_q;
		if (msrWrEn)
			msr_d = msrWdata;
		if (rfiTake) begin
			msr_d[`CMS_MSR_SAVE_A] = rfiBits[0];
			msr_d[`CMS_MSR_SAVE_B] = rfiBits[1];
			msr_d[`CMS_MSR_SAVE_C] = rfiBits[2];
		end
		if (irqTake)
			msr_d[`CMS_MSR_BYTE_SWAP] = msr_q[`CMS_MSR_IRQ_ORDER];
	end

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			msr_q     <= `CMS_MSR_RST;
			savedBits <= 3'h0;
		end else begin
			msr_q <= msr_d;
			if (irqTake)
				savedBits <= {msr_q[`CMS_MSR_SAVE_A], msr_q[`CMS_MSR_SAVE_B],
					msr_q[`CMS_MSR_SAVE_C]};
		end
	end

	// ------------------------------------------------------------------
	// condition flags
	// ------------------------------------------------------------------
	// one lane per field picks the moved or the held nibble
	wire [0:31] crMoveMerged;

	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : gFieldMove
			assign crMoveMerged[4*g +: 4] = crMoveMask[g] ?
				crMoveData[4*g +: 4] : cr_q[4*g +: 4];
		end
	endgenerate

	// later writers win; the pipeline issues one writer per field per cycle
	always @* begin
		cr_d = cr_q;
		if (crMoveEn)
			cr_d = crMoveMerged;
		if (crLogicEn)
			cr_d[crLogicBit] = crLogicVal;
		if (cmpEn)
			cr_d[4*cmpField +: 4] = cmpResult;
		if (intResultEn)
			cr_d[0:3] = integerResultField;
		if (fpResultEn)
			cr_d[4:7] = floatResultField;
		if (xerCopyEn)
			cr_d[4*xerCopyField +: 4] = xer_q[0:3];
	end

	// ------------------------------------------------------------------
	// fixed exception cause
	// ------------------------------------------------------------------
	always @* begin
		xer_d = xer_q;
		if (xerMove)
			xer_d = {sprWdata[0:2], 22'h00_0000, sprWdata[`CMS_XER_BCNT_LSB:31]};
		if (xerCopyEn) begin
			xer_d[`CMS_XER_STICKY] = 1'b0;
			xer_d[`CMS_XER_WRAP]   = 1'b0;
			xer_d[`CMS_XER_SPILL]  = 1'b0;
		end
		if (spillUpdEn)
			xer_d[`CMS_XER_SPILL] = spillVal;
		if (wrapUpdEn) begin
			xer_d[`CMS_XER_WRAP] = wrapVal;
			// set beats a same-cycle clear so an overflow is never lost
			if (wrapVal)
				xer_d[`CMS_XER_STICKY] = 1'b1;
		end
	end

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cr_q  <= `CMS_CR_RST;
			xer_q <= `CMS_XER_RST;
		end else begin
			cr_q  <= cr_d;
			xer_q <= xer_d;
		end
	end

	// ------------------------------------------------------------------
	// decoded controls
	// ------------------------------------------------------------------
	assign machineState        = msr_q;
	assign conditionFlags      = cr_q;
	assign fixedExceptionCause = xer_q;

	assign lowPowerMode   = msr_q[`CMS_MSR_LOW_ENERGY];
	assign extIrqAccept   = extIrqReq & msr_q[`CMS_MSR_EXT_IRQ_EN];
	assign decIrqAccept   = decIrqReq & msr_q[`CMS_MSR_EXT_IRQ_EN];
	assign privFault      = privInstr & msr_q[`CMS_MSR_USER];
	assign fpFault        = fpInstr & ~msr_q[`CMS_MSR_FLOAT_AVAIL];
	assign mcheckAccept   = mcheckReq & msr_q[`CMS_MSR_MCHECK_EN];
	assign floatExcMode   = {msr_q[`CMS_MSR_FEXC_A], msr_q[`CMS_MSR_FEXC_B]};
	// without trace support both bits are plain stored bits
	assign stepTraceEn    = `CMS_TRACE_IMPL & msr_q[`CMS_MSR_STEP_TRACE];
	assign branchTraceEn  = `CMS_TRACE_IMPL & msr_q[`CMS_MSR_BRANCH_TRACE];
	assign vectorPrefix   = msr_q[`CMS_MSR_VEC_HIGH] ? `CMS_VEC_HIGH : `CMS_VEC_LOW;
	assign fetchTranslate = msr_q[`CMS_MSR_FETCH_XLATE];
	assign dataTranslate  = msr_q[`CMS_MSR_DATA_XLATE];
	assign irqRecoverable = msr_q[`CMS_MSR_RESTART];
	assign littleEndian   = msr_q[`CMS_MSR_BYTE_SWAP];

endmodule

// ### design/cms_core_machine_state_regs.vh
// constants for the core machine state register block
`ifndef CMS_CORE_MACHINE_STATE_REGS_VH
`define CMS_CORE_MACHINE_STATE_REGS_VH

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define CMS_MSR_RST          32'h0000_0000
`define CMS_CR_RST           32'h0000_0000
`define CMS_XER_RST          32'h0000_0000

// ------------------------------------------------------------------
// machine_state bit positions (bit 0 is the most significant)
// ------------------------------------------------------------------
`define CMS_MSR_SAVE_A       0
`define CMS_MSR_SAVE_B       5
`define CMS_MSR_SAVE_C       9
`define CMS_MSR_LOW_ENERGY   13
`define CMS_MSR_IRQ_ORDER    15
`define CMS_MSR_EXT_IRQ_EN   16
`define CMS_MSR_USER         17
`define CMS_MSR_FLOAT_AVAIL  18
`define CMS_MSR_MCHECK_EN    19
`define CMS_MSR_FEXC_A       20
`define CMS_MSR_STEP_TRACE   21
`define CMS_MSR_BRANCH_TRACE 22
`define CMS_MSR_FEXC_B       23
`define CMS_MSR_VEC_HIGH     25
`define CMS_MSR_FETCH_XLATE  26
`define CMS_MSR_DATA_XLATE   27
`define CMS_MSR_RESTART      30
`define CMS_MSR_BYTE_SWAP    31

// ------------------------------------------------------------------
// fixed_exception_cause bit positions
// ------------------------------------------------------------------
`define CMS_XER_STICKY       0
`define CMS_XER_WRAP         1
`define CMS_XER_SPILL        2
`define CMS_XER_BCNT_LSB     25

// ------------------------------------------------------------------
// special register numbers and decode targets
// ------------------------------------------------------------------
`define CMS_SPR_XER_HI       5'h00
`define CMS_SPR_XER_LO       5'h01
`define CMS_SPR_DPI_HI       5'h13
`define CMS_SPR_DPI_LO       5'h17
`define CMS_VEC_LOW          12'h000
`define CMS_VEC_HIGH         12'hFFF
`define CMS_TRACE_IMPL       1'b1

`define CMS_TGT_NONE         3'h0
`define CMS_TGT_TIMER        3'h1
`define CMS_TGT_CORE_EXT     3'h2
`define CMS_TGT_SIU          3'h3
`define CMS_TGT_IMMU         3'h4
`define CMS_TGT_DMMU         3'h5
`define CMS_TGT_ICACHE       3'h6
`define CMS_TGT_DCACHE       3'h7

`endif

// ### tb/cms_core_machine_state_regs_props.sv
// assertion checker for the core machine state register block
`timescale 1ns/100ps
module cms_core_machine_state_regs_props (
	// clock and reset
	input logic        ref_clk,
	input logic        nrst,
	// move and bus
	input logic [4:0]  sprLo,
	input logic [4:0]  sprHi,
	input logic        sprAck,
	input logic        sprBusy,
	input logic        emulIrq,
	input logic        busReq,
	input logic [0:31] busAddr,
	input logic [2:0]  busTarget,
	input logic        busAck,
	input logic        busErr,
	// state
	input logic        irqTake,
	input logic [0:2]  savedBits,
	input logic [0:31] machineState,
	input logic        extIrqReq,
	input logic        extIrqAccept,
	input logic        wrapUpdEn,
	input logic        wrapVal,
	input logic [0:31] fixedExceptionCause
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	property p_addrZero; busReq |-> busAddr[0:17] == 18'h0 && busAddr[28:31] == 4'h0; endproperty
	a_addrZero: assert property (p_addrZero) else $error("bus address pad bits");
	property p_addrNum;
		$rose(busReq) |-> busAddr[18:22] == $past(sprLo) && busAddr[23:27] == $past(sprHi);
	endproperty
	a_addrNum: assert property (p_addrNum) else $error("bus address number");
	property p_err; busReq && busErr |=> sprAck && emulIrq; endproperty
	a_err: assert property (p_err) else $error("bus error not reported");
	property p_ok; busReq && busAck && !busErr |=> sprAck && !emulIrq; endproperty
	a_ok: assert property (p_ok) else $error("bus ack misreported");
	property p_siu; busReq && busAddr[23:27] == 5'h13 && !busAddr[19] |-> busTarget == 3'h3;
	endproperty
	a_siu: assert property (p_siu) else $error("interface unit target");
	property p_mmu; busReq && busAddr[23:26] == 4'hC |-> busTarget == (busAddr[19] ? 3'h5 : 3'h4);
	endproperty
	a_mmu: assert property (p_mmu) else $error("mmu target");
	property p_save; irqTake |=> savedBits == {$past(machineState[0]), $past(machineState[5]),
		$past(machineState[9])} && machineState[31] == $past(machineState[15]); endproperty
	a_save: assert property (p_save) else $error("interrupt entry state");
	property p_ext; extIrqAccept == (extIrqReq && machineState[16]); endproperty
	a_ext: assert property (p_ext) else $error("external accept");
	property p_sticky; wrapUpdEn && wrapVal |=> fixedExceptionCause[0:1] == 2'b11; endproperty
	a_sticky: assert property (p_sticky) else $error("sticky overflow");
	property p_busy; sprBusy == busReq; endproperty
	a_busy: assert property (p_busy) else $error("busy flag");
	c_err: cover property (busReq && busErr);
	c_ok: cover property (busReq && busAck);
	c_irq: cover property (irqTake);
endmodule

// ### tb/cms_bus_partner.sv
// internal chip bus responder with settable wait and error
`timescale 1ns/100ps
module cms_bus_partner (
	// clock and reset
	input logic        ref_clk,
	input logic        nrst,
	// bus
	input logic        busReq,
	input logic [0:31] busAddr,
	output logic       busAck,
	output logic       busErr,
	output logic [0:31] busRdata,
	// behaviour
	input logic        errMode,
	input logic [1:0]  dly
);
	logic [1:0] n;
	// idle data toggles so a stale sample never looks right
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			{busAck, busErr, n} <= '0;
			busRdata <= 32'h0000_0000;
		end else if (busReq && !busAck && !busErr && n == dly) begin
			busAck <= !errMode;
			busErr <= errMode;
			busRdata <= busAddr ^ 32'h5A5A_0000;
			n <= 2'h0;
		end else begin
			{busAck, busErr} <= 2'b00;
			busRdata <= ~busRdata;
			n <= busReq ? n + 2'h1 : 2'h0;
		end
	end
endmodule

// ### tb/cms_core_machine_state_regs_tb.sv
// self-checking bench for the core machine state register block
`timescale 1ns/100ps
module cms_core_machine_state_regs_tb;
	logic ref_clk, nrst, sprReq, sprWrite, sprBusy, sprAck, emulIrq, busReq, busWrite, busAck;
	logic busErr, msrWrEn, irqTake, rfiTake, crMoveEn, crLogicEn, crLogicVal, cmpEn, intResultEn;
	logic fpResultEn, xerCopyEn, wrapUpdEn, wrapVal, spillUpdEn, spillVal, extIrqReq, decIrqReq;
	logic mcheckReq, privInstr, fpInstr, extIrqAccept, decIrqAccept, mcheckAccept, privFault;
	logic fpFault, lowPowerMode, stepTraceEn, branchTraceEn, fetchTranslate, dataTranslate;
	logic irqRecoverable, littleEndian, errMode, sawBus, gotE, w, gotWr;
	logic [4:0] sprLo, sprHi, crLogicBit, h, l;
	logic [2:0] cmpField, xerCopyField, busTarget, gotT, t;
	logic [0:7] crMoveMask;
	logic [0:3] cmpResult, integerResultField, floatResultField;
	logic [0:2] rfiBits, savedBits;
	logic [1:0] floatExcMode, dly;
	logic [11:0] vectorPrefix;
	logic [0:31] sprWdata, msrWdata, crMoveData, sprRdata, busAddr, busWdata, busRdata, d;
	logic [0:31] machineState, conditionFlags, fixedExceptionCause, m, c, x, gotA, gotW;
	logic [12:0] tbl [0:6];
	int errors, check_count, cyc, i, j;
	cms_core_machine_state_regs i_dut (.*);
	cms_bus_partner i_partner (.*);
	// ----------------------------------------
	// clock, timeout, bus monitor
	// ----------------------------------------
	initial begin
		ref_clk = 0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (busReq === 1'b1)
			{sawBus, gotA, gotT, gotWr, gotW} <= {1'b1, busAddr, busTarget, busWrite, busWdata};
		cyc++;
		if (cyc == 5000) begin
			errors++;
			end_sim;
		end
	end
	task chk(input logic [0:31] a, input logic [0:31] e);
		check_count++;
		if (a !== e) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, a, e);
		end
	endtask
	// request held until the ack shows, then dropped
	task spr(input logic wr, input logic [4:0] hi, input logic [4:0] lo, input logic [0:31] dat);
		int n;
		n = 0;
		{sawBus, sprReq, sprWrite, sprHi, sprLo, sprWdata} = {2'b01, wr, hi, lo, dat};
		@(negedge ref_clk);
		while (sprAck !== 1'b1 && n < 50) begin
			@(negedge ref_clk);
			n++;
		end
		chk(32'(sprAck), 32'h1);
		gotE = emulIrq;
		sprReq = 0;
		// let an edge pass so the next call never re-raises in this time step
		@(negedge ref_clk);
	endtask
	task end_sim;
		$display("errors=%0d checks=%0d", errors, check_count);
		if (errors == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(22523));
		{nrst, sprReq, sprWrite, sprLo, sprHi, sprWdata, msrWrEn, msrWdata, irqTake, rfiTake} = '0;
		{rfiBits, crMoveEn, crMoveMask, crMoveData, crLogicEn, crLogicBit, crLogicVal, cmpEn} = '0;
		{cmpField, cmpResult, intResultEn, integerResultField, fpResultEn, floatResultField} = '0;
		{xerCopyEn, xerCopyField, wrapUpdEn, wrapVal, spillUpdEn, spillVal, extIrqReq} = '0;
		{decIrqReq, mcheckReq, privInstr, fpInstr, errMode, dly, c, x} = '0;
		tbl = '{{5'h13, 5'h06, 3'h3}, {5'h18, 5'h10, 3'h4}, {5'h18, 5'h18, 3'h5},
			{5'h11, 5'h10, 3'h6}, {5'h11, 5'h18, 3'h7}, {5'h02, 5'h10, 3'h1}, {5'h10, 5'h00, 3'h2}};
		repeat (10) @(negedge ref_clk);
		nrst = 1;
		for (i = 0; i < 14; i++) begin
			{h, l, t} = tbl[i % 7];
			dly = $urandom;
			w = i / 7;
			d = $urandom;
			spr(w, h, l, d);
			chk(gotA, {18'h0, l, h, 4'h0});
			chk(32'(gotWr), 32'(w));
			if (w) chk(gotW, d);
			chk(32'(gotT), 32'(t));
			if (!w) chk(sprRdata, {18'h0, l, h, 4'h0} ^ 32'h5A5A_0000);
		end
		errMode = 1;
		spr(0, 5'h18, 5'h12, 0);
		chk(32'(gotE), 32'h1);
		errMode = 0;
		spr(0, 5'h14, 5'h00, 0);
		chk(32'({gotE, sawBus}), 32'h2);
		spr(1, 5'h13, 5'h17, $urandom);
		chk(32'({gotE, sawBus}), 32'h0);
		spr(0, 5'h13, 5'h17, 0);
		chk(32'(sawBus), 32'h0);
		chk(sprRdata, 32'h0);
		// cause register: move, sticky set, compare, carry with copy-out
		d = ($urandom & 32'h1FFF_FFFF) | 32'h4000_0000;
		spr(1, 5'h00, 5'h01, d);
		x = d & 32'hE000_007F;
		chk(fixedExceptionCause, x);
		{wrapUpdEn, wrapVal} = 2'b11;
		@(negedge ref_clk);
		x[0:1] = 2'b11;
		chk(fixedExceptionCause, x);
		{wrapVal, cmpEn, cmpField, cmpResult} = {2'b01, 3'h3, 4'h9};
		@(negedge ref_clk);
		{wrapUpdEn, cmpEn, x[1], c[12+:4]} = {3'b000, 4'h9};
		chk(fixedExceptionCause, x);
		{spillUpdEn, spillVal, xerCopyEn, xerCopyField} = {3'b111, 3'h5};
		@(negedge ref_clk);
		{spillUpdEn, xerCopyEn, c[20+:4], x[0:2]} = {2'b00, x[0:3], 3'b001};
		chk(fixedExceptionCause, x);
		chk(conditionFlags, c);
		{crLogicEn, fpResultEn, crLogicBit, crLogicVal, floatResultField} = {2'b11, 10'($urandom)};
		@(negedge ref_clk);
		c[crLogicBit] = crLogicVal;
		c[4:7] = floatResultField;
		{crLogicEn, fpResultEn} = 2'b00;
		chk(conditionFlags, c);
		spr(0, 5'h00, 5'h01, 0);
		chk(sprRdata, x);
		// machine state fields, interrupt entry and return
		for (i = 0; i < 16; i++) begin
			{crMoveMask, crMoveData, integerResultField, intResultEn} = {$urandom, $urandom, i[1:0]};
			{m, msrWdata, crMoveEn, msrWrEn} = {2{$urandom}} << 2 | 2'b11;
			{extIrqReq, decIrqReq, mcheckReq, privInstr, fpInstr} = $urandom;
			@(negedge ref_clk);
			{crMoveEn, msrWrEn} = 2'b00;
			m = msrWdata;
			for (j = 0; j < 8; j++) if (crMoveMask[j]) c[j*4+:4] = crMoveData[j*4+:4];
			if (intResultEn) c[0:3] = integerResultField;
			chk(conditionFlags, c);
			chk(machineState, m);
			chk({vectorPrefix, lowPowerMode, floatExcMode, stepTraceEn, branchTraceEn, fetchTranslate,
				dataTranslate, irqRecoverable, littleEndian, extIrqAccept, decIrqAccept, mcheckAccept,
				privFault, fpFault, 6'h0}, {m[25] ? 12'hFFF : 12'h000, m[13], m[20], m[23], m[21],
				m[22], m[26], m[27], m[30], m[31], extIrqReq & m[16], decIrqReq & m[16],
				mcheckReq & m[19], privInstr & m[17], fpInstr & ~m[18], 6'h0});
			irqTake = 1;
			@(negedge ref_clk);
			{irqTake, rfiTake, rfiBits} = {2'b01, 3'($urandom)};
			chk(32'(savedBits), 32'({m[0], m[5], m[9]}));
			m[31] = m[15];
			chk(machineState, m);
			@(negedge ref_clk);
			{rfiTake, m[0], m[5], m[9]} = {1'b0, rfiBits};
			chk(machineState, m);
		end
		end_sim;
	end
endmodule
bind cms_core_machine_state_regs cms_core_machine_state_regs_props i_props (.ref_clk, .nrst,
	.sprLo, .sprHi, .sprAck, .sprBusy, .emulIrq, .busReq, .busAddr, .busTarget, .busAck, .busErr,
	.irqTake,
	.savedBits, .machineState, .extIrqReq, .extIrqAccept, .wrapUpdEn, .wrapVal,
	.fixedExceptionCause);
